// ---- verilog/tmr_pkg.sv ----
// How it works
// - Run bit clear zeroes and stops counter
// - Mode bit picks clear-on-match or PWM
// - Preset bits force output flip-flop level
// - Bit 1 inverts on match or sets level
// - Output enable low drives pin low
// - Preset bits read back as zero
// - Presets ignored while in PWM mode
// - PWM output inactive when run cleared
// - Settings reach the pin one clock later, through a register
// - Mode control resets to 00H
// - Mode control writable bytewise only
// - Direction 0 output, 1 input
// - Direction registers reset to FFH
// - Match clears count, counts on, interrupts
// - Clock select bits 0-2 pick count clock
// - Interrupt period is compare plus one
// - Count increments per count clock, read-only
`default_nettype none
package tmr_pkg;
    localparam logic [15:0] TMR_ADDR_PORT1_DIR = 16'hFF21;
    localparam logic [15:0] TMR_ADDR_PORT3_DIR = 16'hFF23;
    localparam logic [15:0] TMR_ADDR_MODE1 = 16'hFF43;
    localparam logic [15:0] TMR_ADDR_MODE0 = 16'hFF6B;
    localparam logic [15:0] TMR_ADDR_CLKSEL0 = 16'hFF6A;
    localparam logic [15:0] TMR_ADDR_CLKSEL1 = 16'hFF8C;
    localparam logic [15:0] TMR_ADDR_CMP0 = 16'hFF80;
    localparam logic [15:0] TMR_ADDR_CMP1 = 16'hFF84;
    localparam logic [15:0] TMR_ADDR_CNT0 = 16'hFF88;
    localparam logic [15:0] TMR_ADDR_CNT1 = 16'hFF90;
    localparam logic [15:0] TMR_ADDR_LATCH = 16'hFF94;
    localparam int TMR_BIT_RUN = 7;
    localparam int TMR_BIT_PWM = 6;
    localparam int TMR_BIT_SET = 3;
    localparam int TMR_BIT_CLR = 2;
    localparam int TMR_BIT_INV = 1;
    localparam int TMR_BIT_OE = 0;
    localparam logic [7:0] TMR_MODE_RST = 8'h00;
    localparam logic [7:0] TMR_DIR_RST = 8'hFF;
    localparam logic [7:0] TMR_MODE_WMASK = 8'hCF;
    localparam logic [7:0] TMR_MODE_RMASK = 8'hC3;
    localparam logic [7:0] TMR_PORT3_FIXED = 8'hF0;
    localparam logic [7:0] TMR_CMP_RST = 8'h00;
    localparam logic [2:0] TMR_CLKSEL_RST = 3'h0;
    localparam int TMR_CH0_DIR_BIT = 7;
    localparam int TMR_CH1_DIR_BIT = 3;
    localparam int TMR_PRE_W = 13;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] cmp;
        logic [2:0] clksel;
    } tmr_cfg_t;
    typedef struct packed {
        logic out_pin;
        logic out_oe;
        logic irq;
    } tmr_pin_t;
endpackage
`default_nettype wire

// ---- verilog/tmr_top.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module tmr_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event input pins, one per channel
    input wire logic [1:0] event_in_pin,
    // Timer output pins and their enables
    output logic [1:0] timer_out_pin,
    output logic [1:0] timer_out_oe,
    // Match interrupt pulses
    output logic [1:0] match_irq
);
    import tmr_pkg::*;

    logic [7:0] port1_direction_reg;
    logic [7:0] port3_direction_reg;
    logic [1:0] pin_latch_reg;
    tmr_cfg_t cfg_reg [2];
    logic [7:0] count_value_reg [2];
    logic [1:0] out_ff_reg;
    logic [1:0] pwm_ff_reg;
    logic [1:0] ev_s1_reg;
    logic [1:0] ev_s2_reg;
    logic [1:0] ev_s3_reg;
    logic [TMR_PRE_W-1:0] pre_reg;
    logic [TMR_PRE_W-1:0] pre_prev_reg;
    logic [1:0] tick;
    logic [1:0] mode_wr;
    logic [7:0] wbyte;
    logic wr;
    logic hit;
    logic [7:0] rd_next;

    assign wr = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];
    assign mode_wr[0] = wr && (paddr == TMR_ADDR_MODE0);
    assign mode_wr[1] = wr && (paddr == TMR_ADDR_MODE1);

    // Prescaler shared by both channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
            pre_prev_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
            pre_prev_reg <= pre_reg;
        end
    end

    // Event pin synchroniser plus edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_s1_reg <= '0;
            ev_s2_reg <= '0;
            ev_s3_reg <= '0;
        end else begin
            ev_s1_reg <= event_in_pin;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
        end
    end

    // Port direction and latch registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_direction_reg <= TMR_DIR_RST;
            port3_direction_reg <= TMR_DIR_RST;
            pin_latch_reg <= '0;
        end else if (wr) begin
            if (paddr == TMR_ADDR_PORT1_DIR) begin
                port1_direction_reg <= wbyte;
            end
            if (paddr == TMR_ADDR_PORT3_DIR) begin
                port3_direction_reg <= wbyte | TMR_PORT3_FIXED;
            end
            if (paddr == TMR_ADDR_LATCH) begin
                pin_latch_reg <= wbyte[1:0];
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic dir_bit;
            logic run;
            logic pwm;
            logic [7:0] mode_nx;
            logic pin_val;
            assign dir_bit = (ch == 0) ? port1_direction_reg[TMR_CH0_DIR_BIT]
                                       : port3_direction_reg[TMR_CH1_DIR_BIT];
            assign run = cfg_reg[ch].mode[TMR_BIT_RUN];
            assign pwm = cfg_reg[ch].mode[TMR_BIT_PWM];
            assign mode_nx = wbyte & TMR_MODE_WMASK;

            always_comb begin
                unique case (cfg_reg[ch].clksel)
                    3'h0: tick[ch] = ev_s3_reg[ch] && !ev_s2_reg[ch];
                    3'h1: tick[ch] = !ev_s3_reg[ch] && ev_s2_reg[ch];
                    3'h2: tick[ch] = 1'b1;
                    3'h3: tick[ch] = pre_reg[0] && !pre_prev_reg[0];
                    3'h4: tick[ch] = (ch == 0) ? (pre_reg[1] && !pre_prev_reg[1])
                                               : (pre_reg[3] && !pre_prev_reg[3]);
                    3'h5: tick[ch] = pre_reg[5] && !pre_prev_reg[5];
                    3'h6: tick[ch] = pre_reg[7] && !pre_prev_reg[7];
                    3'h7: tick[ch] = (ch == 0) ? (pre_reg[12] && !pre_prev_reg[12])
                                               : (pre_reg[11] && !pre_prev_reg[11]);
                endcase
            end

            // Configuration registers
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_reg[ch].mode <= TMR_MODE_RST;
                    cfg_reg[ch].cmp <= TMR_CMP_RST;
                    cfg_reg[ch].clksel <= TMR_CLKSEL_RST;
                end else if (wr) begin
                    // whole byte write, single bits by read-modify-write
                    if (mode_wr[ch]) begin
                        cfg_reg[ch].mode <= mode_nx;
                    end
                    if (paddr == ((ch == 0) ? TMR_ADDR_CMP0 : TMR_ADDR_CMP1)) begin
                        cfg_reg[ch].cmp <= wbyte;
                    end
                    if (paddr == ((ch == 0) ? TMR_ADDR_CLKSEL0 : TMR_ADDR_CLKSEL1)) begin
                        cfg_reg[ch].clksel <= wbyte[2:0];
                    end
                end
            end

            // Counter and match interrupt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    count_value_reg[ch] <= '0;
                    match_irq[ch] <= 1'b0;
                end else begin
                    match_irq[ch] <= 1'b0;
                    if (!run) begin
                        count_value_reg[ch] <= '0;
                    end else if (tick[ch]) begin
                        if (!pwm && count_value_reg[ch] == cfg_reg[ch].cmp) begin
                            count_value_reg[ch] <= '0;
                            match_irq[ch] <= 1'b1;
                        end else begin
                            count_value_reg[ch] <= count_value_reg[ch] + 1'b1;
                        end
                    end
                end
            end

            // Timer output flip-flop
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_ff_reg[ch] <= 1'b0;
                end else if (mode_wr[ch] && !wbyte[TMR_BIT_PWM] && !pwm
                             && (wbyte[TMR_BIT_SET] ^ wbyte[TMR_BIT_CLR])) begin
                    out_ff_reg[ch] <= wbyte[TMR_BIT_SET];
                end else if (run && !pwm && tick[ch] && cfg_reg[ch].mode[TMR_BIT_INV]
                             && count_value_reg[ch] == cfg_reg[ch].cmp) begin
                    out_ff_reg[ch] <= !out_ff_reg[ch];
                end
            end

            // PWM flip-flop: active from overflow to match
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_ff_reg[ch] <= 1'b0;
                end else if (!run || !pwm) begin
                    pwm_ff_reg[ch] <= 1'b0;
                end else if (tick[ch]) begin
                    if (count_value_reg[ch] == 8'hFF) begin
                        pwm_ff_reg[ch] <= (cfg_reg[ch].cmp != 8'h00);
                    end else if (count_value_reg[ch] + 8'h01 == cfg_reg[ch].cmp) begin
                        pwm_ff_reg[ch] <= 1'b0;
                    end
                end
            end

            // PWM level select, enable gates pin low
            assign pin_val = cfg_reg[ch].mode[TMR_BIT_OE]
                && ~pin_latch_reg[ch]
                && (pwm ? (pwm_ff_reg[ch] ^ cfg_reg[ch].mode[TMR_BIT_INV]) : out_ff_reg[ch]);

            // pin follows settings every cycle, direction 0 drives
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    timer_out_pin[ch] <= 1'b0;
                    timer_out_oe[ch] <= 1'b0;
                end else begin
                    timer_out_pin[ch] <= pin_val;
                    timer_out_oe[ch] <= !dir_bit;
                end
            end
        end
    endgenerate

    // Read mux
    always_comb begin
        unique case (paddr)
            TMR_ADDR_PORT1_DIR: rd_next = port1_direction_reg;
            TMR_ADDR_PORT3_DIR: rd_next = port3_direction_reg;
            TMR_ADDR_MODE0: rd_next = cfg_reg[0].mode & TMR_MODE_RMASK;
            TMR_ADDR_MODE1: rd_next = cfg_reg[1].mode & TMR_MODE_RMASK;
            TMR_ADDR_CLKSEL0: rd_next = {5'h00, cfg_reg[0].clksel};
            TMR_ADDR_CLKSEL1: rd_next = {5'h00, cfg_reg[1].clksel};
            TMR_ADDR_CMP0: rd_next = cfg_reg[0].cmp;
            TMR_ADDR_CMP1: rd_next = cfg_reg[1].cmp;
            TMR_ADDR_CNT0: rd_next = count_value_reg[0];
            TMR_ADDR_CNT1: rd_next = count_value_reg[1];
            TMR_ADDR_LATCH: rd_next = {6'h00, pin_latch_reg};
            default: rd_next = 8'h00;
        endcase
    end

    assign hit = (paddr == TMR_ADDR_PORT1_DIR) || (paddr == TMR_ADDR_PORT3_DIR)
        || (paddr == TMR_ADDR_MODE0) || (paddr == TMR_ADDR_MODE1)
        || (paddr == TMR_ADDR_CLKSEL0) || (paddr == TMR_ADDR_CLKSEL1)
        || (paddr == TMR_ADDR_CMP0) || (paddr == TMR_ADDR_CMP1)
        || (paddr == TMR_ADDR_CNT0) || (paddr == TMR_ADDR_CNT1)
        || (paddr == TMR_ADDR_LATCH);

    // APB answer registered in setup cycle; zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_next} : 32'h00000000;
        end
    end
endmodule // tmr_top
`default_nettype wire

// ---- dv/tmr_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_model (
    // Clock
    input wire logic pclk,
    // Bench pulses and timer side
    input wire logic [1:0] req,
    input wire logic [1:0] out_pin,
    input wire logic [1:0] out_oe,
    // Pin level seen by the timer
    output logic [1:0] ev
);
    initial ev = 2'h0;
    always @(posedge pclk) begin
        ev <= (out_oe & out_pin) | (~out_oe & req);
    end
endmodule // tmr_pin_model
`default_nettype wire

// ---- dv/tmr_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module tmr_assertions
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupts
    input wire logic [1:0] match_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        pready && psel && penable && !pwrite;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready && psel && penable)
        else $error("no answer in access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_read_upper_zero: assert property (s_read |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_mode_read_mask: assert property ((s_read and (paddr == TMR_ADDR_MODE0 ||
        paddr == TMR_ADDR_MODE1)) |-> prdata[5:2] == 4'h0) else $error("mode bits 5:2 read set");
    a_port3_fixed: assert property ((s_read and (paddr == TMR_ADDR_PORT3_DIR)) |->
        prdata[7:4] == 4'hF) else $error("port3 upper bits not one");
    a_irq0_pulse: assert property (match_irq[0] |=> !match_irq[0])
        else $error("irq0 longer than one cycle");
    a_irq1_pulse: assert property (match_irq[1] |=> !match_irq[1])
        else $error("irq1 longer than one cycle");
endmodule // tmr_assertions
bind tmr_top tmr_assertions tmr_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .match_irq);
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tmr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, p;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [1:0] ev, req = 2'h0, timer_out_pin, timer_out_oe, match_irq;
    logic pready, pslverr;
    logic [7:0] cmp, d;
    int failures = 0, compares = 0, cyc = 0, n, irq1_n = 0;
    always #4 pclk = ~pclk;
    tmr_top tmr_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .event_in_pin(ev), .timer_out_pin, .timer_out_oe, .match_irq);
    tmr_pin_model tmr_pin_model_inst (.pclk, .req, .out_pin(timer_out_pin),
        .out_oe(timer_out_oe), .ev);
    task summarize;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, x, g);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [7:0] dd);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, dd};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task pin_chk(input logic x);
        repeat (3) @(negedge pclk);
        chk("pin0", {31'h0, x}, {31'h0, timer_out_pin[0]});
    endtask
    task wait_irq;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (match_irq[0] !== 1'b1 && n < 600);
    endtask
    always @(negedge pclk) if (match_irq[1] === 1'b1) irq1_n++;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h8BFA));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, TMR_ADDR_PORT1_DIR, 0); chk("port1", 32'hFF, r);
        apb(0, TMR_ADDR_PORT3_DIR, 0); chk("port3", 32'hFF, r);
        apb(0, TMR_ADDR_MODE0, 0); chk("mode0", 32'h0, r);
        apb(0, TMR_ADDR_MODE1, 0); chk("mode1", 32'h0, r);
        apb(0, 16'hFF00, 0); chk("unmapped", 32'h1, {31'h0, e});
        apb(1, TMR_ADDR_PORT3_DIR, 8'h07);
        apb(0, TMR_ADDR_PORT3_DIR, 0); chk("port3 fixed", 32'hF7, r);
        chk("oe1", 32'h1, {31'h0, timer_out_oe[1]});
        apb(1, TMR_ADDR_PORT3_DIR, 8'h0F);
        apb(1, TMR_ADDR_LATCH, 8'h00);
        apb(1, TMR_ADDR_PORT1_DIR, 8'h7F);
        pin_chk(0); chk("oe0", 32'h1, {31'h0, timer_out_oe[0]});
        apb(1, TMR_ADDR_MODE0, 8'h08); pin_chk(0);
        apb(1, TMR_ADDR_MODE0, 8'h01); pin_chk(1);
        apb(0, TMR_ADDR_MODE0, 0); chk("mode0 preset", 32'h01, r);
        apb(1, TMR_ADDR_MODE0, 8'h05); pin_chk(0);
        apb(1, TMR_ADDR_CLKSEL0, 8'h02);
        apb(1, TMR_ADDR_MODE0, 8'h02);
        apb(1, TMR_ADDR_MODE0, 8'h03);
        for (int k = 0; k < 3; k++) begin
            cmp = (k == 0) ? 8'hFF : 8'h04 + 8'($urandom % 40);
            apb(1, TMR_ADDR_CMP0, cmp);
            apb(1, TMR_ADDR_MODE0, 8'h83);
            wait_irq();
            p = timer_out_pin[0];
            wait_irq();
            chk("period", 32'(cmp) + 1, n);
            chk("toggle", {31'h0, ~p}, {31'h0, timer_out_pin[0]});
            apb(1, TMR_ADDR_MODE0, 8'h03);
            apb(0, TMR_ADDR_CNT0, 0); chk("count stop", 32'h0, r);
        end
        for (int lv = 0; lv < 2; lv++) begin
            d = 8'h41 | 8'(lv << 1);
            apb(1, TMR_ADDR_MODE0, d);
            apb(1, TMR_ADDR_CMP0, 8'h80);
            apb(1, TMR_ADDR_MODE0, d | 8'h80);
            repeat (300) @(negedge pclk);
            apb(1, TMR_ADDR_MODE0, d); pin_chk(lv[0]);
            apb(1, TMR_ADDR_MODE0, d | 8'h08); pin_chk(lv[0]);
        end
        apb(1, TMR_ADDR_CLKSEL1, 8'h01);
        apb(1, TMR_ADDR_CMP1, 8'h02);
        apb(1, TMR_ADDR_MODE1, 8'h80);
        repeat (6) begin
            @(posedge pclk) req <= 2'b10;
            repeat (4) @(posedge pclk);
            req <= 2'b00;
            repeat (4) @(posedge pclk);
        end
        repeat (10) @(negedge pclk);
        chk("event irqs", 32'd2, irq1_n);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
